// >>> hw/touch_pkg.sv
// constants shared by the touch result output engine and its timers.
// assumes a single 250 MHz system clock.
package touch_pkg;
	localparam int CLK_PERIOD_NS   = 4;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYC          = MS_NS / CLK_PERIOD_NS;
	localparam int BUZZ_MIN_HZ     = 1000;
	localparam int BUZZ_MAX_HZ     = 4000;
	localparam int BUZZ_HALF_1K_CYC =
		1000000000 / (CLK_PERIOD_NS * 2 * BUZZ_MIN_HZ);
	localparam int BEEP_HZ         = 2;
	localparam int BEEP_HALF_MS    = 1000 / (2 * BEEP_HZ);
	localparam int BEEP_TOTAL_MS   = 2000;
	localparam int DELTA_SHIFT     = 4;
	localparam int DELTA_W         = 8;
	localparam int BL_W            = DELTA_W + DELTA_SHIFT;
	localparam int MS_CNT_W        = 16;

	typedef enum logic [1:0] {
		ST_CHECK = 2'b00,
		ST_BEEP  = 2'b01,
		ST_RUN   = 2'b11
	} test_st_t;
endpackage

// >>> hw/touch_timer_if.sv
// carrier between the output engine and one touch-duration timer.
// one instance per sensing input; all signals on i_clk_sys.
interface touch_timer_if;
	logic                              run;
	logic                              tick;
	logic [touch_pkg::MS_CNT_W-1:0]    limit;
	logic                              expire;
	modport ctl (output run, output tick, output limit, input expire);
	modport tmr (input run, input tick, input limit, output expire);
endinterface

// >>> hw/touch_timer.sv
// touch-duration timer for one sensing input, counted in ms ticks.
// assumes tick is a one-cycle pulse once per millisecond.
module touch_timer (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	touch_timer_if.tmr tif
);
	typedef struct packed {
		logic [touch_pkg::MS_CNT_W-1:0] cnt;
		logic                           expire;
	} tmr_state_t;

	tmr_state_t r;
	tmr_state_t n;

	always_comb begin
		n = r;
		n.expire = 1'b0;
		if (!tif.run) begin
			n.cnt = '0;
		end else if (tif.tick) begin
			if (r.cnt + 1'b1 >= tif.limit) begin
				n.expire = 1'b1;
				n.cnt = '0;
			end else begin
				n.cnt = r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign tif.expire = r.expire;

	AST_TMR_IDLE: assert property ( // RULE8
		@(posedge i_clk_sys) disable iff (i_rst)
		!tif.run |=> r.cnt == '0)
		else $error("timer count held while not running");
endmodule

// >>> hw/touch_out_engine.sv
// touch result output engine: pins, arbiter, time-out, buzzer, self test.
// assumes qualified touch levels synchronous to i_clk_sys from the qualifier.
// What this block does (RULE6 is left to the host)
// RULE1: each input's qualified touch sets its own pin active or inactive.
// RULE2: one global setting picks active-high or active-low touch pins.
// RULE3: one global setting picks open-drain or push-pull for all touch pins.
// RULE4: proximity detect wakes the device to qualify enabled inputs.
// RULE5: proximity state goes to one chosen pin, removing its paired input.
// RULE6: host should pick the sensing input paired with the proximity pin.
// RULE7: proximity input never qualifies, arbitrates, buzzes or times out.
// RULE8: time-out enabled gives each input its own timer; disabled runs none.
// RULE9: a touch held past the time-out gets a forced release.
// RULE10: forced release adds the input's touch delta to its baseline.
// RULE11: after forced release the baseline tracks downward aggressively.
// RULE12: one global time-out value serves every input.
// RULE13: with exclusive mode, only the reported input's timer runs.
// RULE14: buzzer square wave starts on each inactive-to-active transition.
// RULE15: buzzer stops at duration end or when the last active input releases.
// RULE16: buzzer frequency selectable from 1 kHz to 4 kHz.
// RULE17: buzzer pin may be push-pull or open-drain.
// RULE18: exclusive mode reports one input, held until it releases.
// RULE19: simultaneous touches report the input with the largest delta.
// RULE20: release reported first, then the highest-index input still touched.
// RULE21: self test disables shorted or open inputs before scanning starts.
// RULE22: any self-test fault toggles the buzzer pin at 2 Hz for two seconds.
// RULE23: stored delta is one sixteenth of the effective delta.
// RULE24: after reset all touch pins inactive and buzzer idle.
module touch_out_engine #(
	parameter int N            = 7,
	parameter int P_MS_CYC     = touch_pkg::MS_CYC,
	parameter int P_BUZZ_HALF  = touch_pkg::BUZZ_HALF_1K_CYC
) (
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rst,
	input  wire logic [N-1:0]           i_qual_touch,
	input  wire logic [N*8-1:0]         i_touch_delta,
	input  wire logic [N-1:0]           i_scan_cfg_en,
	input  wire logic                   i_cfg_active_high,
	input  wire logic                   i_cfg_open_drain,
	input  wire logic                   i_prox_enable,
	input  wire logic [2:0]             i_prox_pin,
	input  wire logic                   i_prox_detect,
	input  wire logic                   i_asleep,
	input  wire logic                   i_timeout_enable,
	input  wire logic [15:0]            i_timeout_ms,
	input  wire logic                   i_excl_enable,
	input  wire logic                   i_buzz_enable,
	input  wire logic [1:0]             i_buzz_freq_sel,
	input  wire logic [15:0]            i_buzz_dur_ms,
	input  wire logic                   i_buzz_open_drain,
	input  wire logic                   i_selftest_enable,
	input  wire logic [N-1:0]           i_selftest_fault,
	output logic [N-1:0]                o_touch_out,
	output logic [N-1:0]                o_touch_oe,
	output logic                        o_buzz,
	output logic                        o_buzz_oe,
	output logic                        o_wake,
	output logic [N-1:0]                o_scan_enable,
	output logic [N-1:0]                o_fault,
	output logic [N-1:0]                o_baseline_add,
	output logic [N*12-1:0]             o_baseline_add_value,
	output logic [N-1:0]                o_fast_track
);
	localparam int BW = touch_pkg::BL_W;

	typedef struct packed {
		touch_pkg::test_st_t st;
		logic [N-1:0]        faulty;
		logic [N-1:0]        forced;
		logic [N-1:0]        fast;
		logic [N-1:0]        rep;
		logic [N-1:0]        rep_prev;
		logic [N-1:0]        qraw_prev;
		logic                after_rel;
		logic                buzz_on;
		logic                wave;
		logic [17:0]         half_cnt;
		logic [15:0]         ms_cnt;
		logic [17:0]         tick_cnt;
		logic                ms_tick;
		logic                wake;
		logic                prox_out;
		logic [N-1:0]        bl_add;
		logic [N*BW-1:0]     bl_val;
	} eng_state_t;

	eng_state_t r;
	eng_state_t n;

	logic [N-1:0] tmr_exp;
	logic [N-1:0] prox_mask;
	logic [N-1:0] touch_mask;
	logic [N-1:0] q;
	logic [17:0]  half_lim;

	// the proximity input is never a touch source
	always_comb begin
		prox_mask = '0;
		if (i_prox_enable) begin
			prox_mask[i_prox_pin] = 1'b1; // RULE5
		end
	end

	assign touch_mask = i_scan_cfg_en & ~r.faulty & ~prox_mask; // RULE7
	assign q = i_qual_touch & touch_mask & ~r.forced; // RULE9

	always_comb begin
		case (i_buzz_freq_sel) // RULE16
			2'd0:    half_lim = 18'(P_BUZZ_HALF);
			2'd1:    half_lim = 18'(P_BUZZ_HALF / 2);
			2'd2:    half_lim = 18'(P_BUZZ_HALF / 3);
			2'd3:    half_lim = 18'(P_BUZZ_HALF / 4);
			default: half_lim = 18'(P_BUZZ_HALF);
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_tmr
			touch_timer_if tif ();
			// one global limit; run only on the externally reported input
			assign tif.run   = i_timeout_enable & r.rep[gi]; // RULE8 RULE12 RULE13
			assign tif.tick  = r.ms_tick;
			assign tif.limit = i_timeout_ms;
			assign tmr_exp[gi] = tif.expire;
			touch_timer u_tmr (
				.i_clk_sys (i_clk_sys),
				.i_rst     (i_rst),
				.tif       (tif)
			);
		end
	endgenerate

	always_comb begin
		logic [BW-1:0]     best;
		logic [BW-1:0]     d;
		logic [N-1:0]      pick_d;
		logic [N-1:0]      pick_hi;
		logic              run_ok;
		best    = '0;
		d       = '0;
		pick_d  = '0;
		pick_hi = '0;
		run_ok  = (r.st != touch_pkg::ST_CHECK);
		n = r;
		n.qraw_prev = i_qual_touch;
		n.rep_prev  = r.rep;
		n.bl_add    = '0;
		n.wake = i_prox_enable & i_prox_detect & i_asleep; // RULE4
		n.prox_out = i_prox_enable & i_prox_detect; // RULE5

		// millisecond time base
		n.ms_tick = 1'b0;
		if (r.tick_cnt >= 18'(P_MS_CYC - 1)) begin
			n.tick_cnt = '0;
			n.ms_tick = 1'b1;
		end else begin
			n.tick_cnt = r.tick_cnt + 1'b1;
		end

		// forced release: set wins over the qualifier's clear
		for (int i = 0; i < N; i++) begin
			d = {i_touch_delta[i*8 +: 8], 4'h0}; // RULE23
			if (tmr_exp[i]) begin
				n.bl_add[i] = 1'b1; // RULE10
				n.bl_val[i*BW +: BW] = d; // RULE10
			end
			if (q[i] && d > best) begin
				best = d;
				pick_d = '0;
				pick_d[i] = 1'b1;
			end
			if (q[i]) begin
				pick_hi = '0;
				pick_hi[i] = 1'b1;
			end
		end
		n.forced = (r.forced & i_qual_touch) | tmr_exp; // RULE9
		// fast tracking ends once a fresh touch qualifies
		n.fast = tmr_exp | (r.fast & ~(i_qual_touch & ~r.qraw_prev
			& ~r.forced)); // RULE11

		// reporting
		if (!run_ok) begin
			n.rep = '0; // RULE24
		end else if (!i_excl_enable) begin
			n.rep = q; // RULE1
		end else if (r.rep != '0) begin // RULE18
			if ((r.rep & q) == '0) begin
				// release shown for one cycle before the next input
				n.rep = '0; // RULE20
				n.after_rel = 1'b1;
			end
		end else if (q != '0) begin
			n.rep = r.after_rel ? pick_hi : pick_d; // RULE19 RULE20
			n.after_rel = 1'b0;
		end else begin
			n.after_rel = 1'b0;
		end

		// self test, then buzzer
		case (r.st)
			touch_pkg::ST_CHECK: begin
				if (i_selftest_enable) begin
					n.faulty = i_selftest_fault & i_scan_cfg_en; // RULE21
				end
				if (i_selftest_enable && (i_selftest_fault & i_scan_cfg_en)
					!= '0) begin
					n.st = touch_pkg::ST_BEEP;
					n.wave = 1'b1;
					n.ms_cnt = '0;
					n.half_cnt = '0;
				end else begin
					n.st = touch_pkg::ST_RUN;
				end
			end
			touch_pkg::ST_BEEP: begin
				if (r.ms_tick) begin
					n.ms_cnt = r.ms_cnt + 1'b1;
					n.half_cnt = r.half_cnt + 1'b1;
					if (r.half_cnt + 1'b1 >=
						18'(touch_pkg::BEEP_HALF_MS)) begin
						n.half_cnt = '0;
						n.wave = ~r.wave; // RULE22
					end
					if (r.ms_cnt + 1'b1 >=
						16'(touch_pkg::BEEP_TOTAL_MS)) begin
						n.st = touch_pkg::ST_RUN; // RULE22
						n.wave = 1'b0;
					end
				end
			end
			touch_pkg::ST_RUN: begin
				if (r.buzz_on) begin
					if (r.half_cnt + 1'b1 >= half_lim) begin
						n.half_cnt = '0;
						n.wave = ~r.wave;
					end else begin
						n.half_cnt = r.half_cnt + 1'b1;
					end
					if (r.ms_tick) begin
						n.ms_cnt = r.ms_cnt + 1'b1;
					end
					if (r.rep == '0 || (r.ms_tick &&
						r.ms_cnt + 1'b1 >= i_buzz_dur_ms)) begin
						n.buzz_on = 1'b0; // RULE15
						n.wave = 1'b0;
					end
				end
				// restart on any fresh report, including re-trigger
				if (i_buzz_enable && (r.rep & ~r.rep_prev) != '0) begin
					n.buzz_on = 1'b1; // RULE14
					n.wave = 1'b1;
					n.half_cnt = '0;
					n.ms_cnt = '0;
				end
			end
			default: begin
				n.st = touch_pkg::ST_CHECK;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// pin levels follow the live polarity setting so a profile change
	// takes effect without waiting for a new event
	always_comb begin
		logic [N-1:0] act;
		logic [N-1:0] lvl;
		act = r.rep; // RULE1
		if (i_prox_enable) begin
			act[i_prox_pin] = r.prox_out; // RULE5
		end
		lvl = i_cfg_active_high ? act : ~act; // RULE2
		if (i_cfg_open_drain) begin
			o_touch_out = '0; // RULE3
			o_touch_oe  = ~lvl;
		end else begin
			o_touch_out = lvl;
			o_touch_oe  = '1;
		end
	end

	assign o_buzz    = i_buzz_open_drain ? 1'b0 : r.wave; // RULE17
	assign o_buzz_oe = i_buzz_open_drain ? r.wave : 1'b1; // RULE17
	assign o_wake        = r.wake;
	assign o_scan_enable = (r.st == touch_pkg::ST_CHECK) ? '0
		: (i_scan_cfg_en & ~r.faulty); // RULE21
	assign o_fault        = r.faulty;
	assign o_baseline_add = r.bl_add;
	assign o_fast_track   = r.fast;

	always_comb begin
		o_baseline_add_value = '0;
		for (int i = 0; i < N; i++) begin
			o_baseline_add_value[i*12 +: 12] = r.bl_val[i*BW +: BW];
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_rst);

	AST_CHECK_QUIET: assert property ( // RULE24
		r.st == touch_pkg::ST_CHECK |-> r.rep == '0 && !r.wave)
		else $error("output active during self test");
	AST_SCAN_HELD: assert property ( // RULE21
		(o_scan_enable & r.faulty) == '0 &&
		(r.st != touch_pkg::ST_CHECK || o_scan_enable == '0))
		else $error("faulty input scanned");
	AST_OD_LOW: assert property ( // RULE3
		i_cfg_open_drain |-> o_touch_out == '0)
		else $error("open-drain pin driven high");
	AST_POL: assert property ( // RULE2
		!i_cfg_open_drain && !i_prox_enable |->
		o_touch_out == (i_cfg_active_high ? r.rep : ~r.rep))
		else $error("touch pin polarity wrong");
	AST_ONE_REP: assert property ( // RULE18
		i_excl_enable && $past(i_excl_enable) |-> $onehot0(r.rep))
		else $error("more than one reported input");
	AST_HOLD_REP: assert property ( // RULE18
		i_excl_enable && r.st == touch_pkg::ST_RUN && (r.rep & q) != '0
		|=> r.rep == $past(r.rep))
		else $error("reported input changed while touched");
	AST_REL_FIRST: assert property ( // RULE20
		i_excl_enable && r.rep != '0 && (r.rep & q) == '0
		|=> r.rep == '0 && r.after_rel)
		else $error("release not reported first");
	AST_NO_PROX: assert property ( // RULE7
		(r.rep & prox_mask) == '0 ##0 (tmr_exp & prox_mask) == '0)
		else $error("proximity input reported as touch");
	AST_FORCE_ADD: assert property ( // RULE10
		tmr_exp != '0 |=> o_baseline_add == $past(tmr_exp)
		##1 o_baseline_add == '0 || $past(tmr_exp) != '0)
		else $error("forced release missed baseline add");
	AST_NO_TMR: assert property ( // RULE8
		!i_timeout_enable [*2] |-> tmr_exp == '0)
		else $error("timer expired while disabled");
	AST_BUZZ_STOP: assert property ( // RULE15
		r.st == touch_pkg::ST_RUN && r.buzz_on && r.rep == '0
		|=> !r.buzz_on && !r.wave)
		else $error("buzzer kept on after last release");
endmodule

// >>> tb/touch_host_model.sv
// host side of the touch pins: works out the level on each wire.
// assumes a pull-up on every line, so a released line reads high.
module touch_host_model #(
	parameter int N = 7
) (
	input  wire logic [N-1:0] i_out,
	input  wire logic [N-1:0] i_oe,
	output logic      [N-1:0] o_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// open drain only ever pulls low; the pull-up supplies the high
	assign o_level = (i_oe & i_out) | ~i_oe;
endmodule

// >>> tb/testbench.sv
// self-checking bench for the touch result output engine.
// assumes shortened ms and buzzer counts; inputs change at falling edges.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int N = 7;
	localparam int MS = 10;
	localparam int HF = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [N-1:0] qual = '0, st_flt = '0, cfg_en = '1;
	logic [N*8-1:0] delta = '0;
	logic act_hi = 1'b1, od = 1'b0, prox_en = 1'b0, prox_det = 1'b0;
	logic asleep = 1'b0, to_en = 1'b0, excl = 1'b0, bz_en = 1'b0;
	logic bz_od = 1'b0, st_en = 1'b0, pv;
	logic [2:0] prox_pin = 3'h3;
	logic [15:0] to_ms = 16'h0002, bz_ms = 16'h0064;
	logic [1:0] bz_sel = 2'h0;
	logic [N-1:0] t_out, t_oe, scan_en, flt, bl_add, fast, lvl;
	logic [N*12-1:0] bl_val;
	logic bz, bz_oe, wake, wave;
	int miscompares = 0;
	int check_count = 0;
	int cyc = 0;
	int n;

	touch_out_engine #(.N(N), .P_MS_CYC(MS), .P_BUZZ_HALF(HF)) u_dut (
		.i_clk_sys(clk), .i_rst(rst), .i_qual_touch(qual),
		.i_touch_delta(delta), .i_scan_cfg_en(cfg_en),
		.i_cfg_active_high(act_hi), .i_cfg_open_drain(od),
		.i_prox_enable(prox_en), .i_prox_pin(prox_pin),
		.i_prox_detect(prox_det), .i_asleep(asleep),
		.i_timeout_enable(to_en), .i_timeout_ms(to_ms),
		.i_excl_enable(excl), .i_buzz_enable(bz_en),
		.i_buzz_freq_sel(bz_sel), .i_buzz_dur_ms(bz_ms),
		.i_buzz_open_drain(bz_od), .i_selftest_enable(st_en),
		.i_selftest_fault(st_flt), .o_touch_out(t_out), .o_touch_oe(t_oe),
		.o_buzz(bz), .o_buzz_oe(bz_oe), .o_wake(wake),
		.o_scan_enable(scan_en), .o_fault(flt), .o_baseline_add(bl_add),
		.o_baseline_add_value(bl_val), .o_fast_track(fast)
	);
	touch_host_model #(.N(N)) u_host (
		.i_out(t_out), .i_oe(t_oe), .o_level(lvl)
	);

	always #2 clk = ~clk;
	assign wave = bz_od ? bz_oe : bz;

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ceiling well above the self test's two-second beep
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			summarize();
		end
	end

	task automatic step(input int k);
		repeat (k) @(negedge clk);
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// pin data, enable and wire level for a set of active inputs
	task automatic pins(input logic [N-1:0] a);
		logic [N-1:0] l;
		logic [N-1:0] oe;
		l = act_hi ? a : ~a;
		oe = od ? ~l : '1;
		chk("touch_out", od ? '0 : l, t_out);
		chk("touch_oe", oe, t_oe);
		chk("pin_level", l, lvl);
	endtask

	task automatic do_reset();
		rst = 1'b1;
		step(3);
		rst = 1'b0;
		step(3);
	endtask

	task automatic wait_add(input logic [N-1:0] m);
		n = 0;
		while ((bl_add & m) == '0 && n < 200) begin
			n++;
			step(1);
		end
	endtask

	task automatic span(input logic v);
		n = 0;
		while (wave === v && n < 40) begin
			n++;
			step(1);
		end
	endtask

	initial begin
		do_reset();
		pins('0);
		chk("buzz", 1'b0, wave);
		for (int k = 0; k < 4; k++) begin
			{act_hi, od} = k[1:0];
			qual = 7'h45;
			step(1);
			pins(7'h45);
			qual = '0;
			step(1);
			pins('0);
		end
		act_hi = 1'b1;
		od = 1'b0;
		// sensor 3 doubles as the proximity sensor, paired with pin 3
		prox_en = 1'b1;
		bz_en = 1'b1;
		qual = 7'h08;
		step(3);
		pins('0);
		chk("wake", 1'b0, wake);
		prox_det = 1'b1;
		asleep = 1'b1;
		step(1);
		chk("wake", 1'b1, wake);
		step(1);
		pins(7'h08);
		chk("buzz", 1'b0, wave);
		prox_en = 1'b0;
		prox_det = 1'b0;
		asleep = 1'b0;
		bz_en = 1'b0;
		qual = '0;
		to_en = 1'b1;
		delta[15:8] = 8'h25;
		delta[39:32] = 8'h03;
		step(2);
		qual = 7'h12;
		wait_add(7'h02);
		chk("expire_wait", 1'b1, n >= MS && n <= 2 * MS + 4);
		chk("add_lanes", 7'h12, bl_add);
		chk("add_val1", 12'h250, bl_val[23:12]);
		chk("add_val4", 12'h030, bl_val[59:48]);
		step(1);
		chk("add_pulse", '0, bl_add);
		pins('0);
		chk("fast", 7'h12, fast);
		qual = '0;
		step(2);
		qual = 7'h02;
		step(2);
		chk("fast", 7'h10, fast);
		pins(7'h02);
		to_en = 1'b0;
		n = 0;
		repeat (6 * MS) begin
			step(1);
			n += (bl_add != '0);
		end
		chk("no_timer", 16'h0, 16'(n));
		qual = '0;
		excl = 1'b1;
		delta[7:0] = 8'h10;
		delta[23:16] = 8'h20;
		step(2);
		qual = 7'h07;
		step(1);
		pins(7'h02);
		qual = 7'h27;
		step(2);
		pins(7'h02);
		qual = 7'h25;
		step(1);
		pins('0);
		step(1);
		pins(7'h20);
		to_en = 1'b1;
		wait_add('1);
		chk("excl_timer", 7'h20, bl_add);
		qual = '0;
		excl = 1'b0;
		to_en = 1'b0;
		bz_en = 1'b1;
		step(3);
		for (int s = 0; s < 4; s++) begin
			bz_sel = s[1:0];
			bz_od = s[0];
			qual = 7'h01;
			step(2);
			chk("buzz_fixed", 1'b1, bz_od ? !bz : bz_oe);
			span(1'b1);
			chk("half_high", 16'(HF / (s + 1)), 16'(n));
			span(1'b0);
			chk("half_low", 16'(HF / (s + 1)), 16'(n));
			qual = '0;
			step(2);
			chk("buzz_stop", 1'b0, wave);
		end
		bz_od = 1'b0;
		bz_ms = 16'h0001;
		qual = 7'h01;
		step(2);
		chk("buzz_start", 1'b1, wave);
		step(2 * MS);
		n = 0;
		repeat (2 * HF) begin
			step(1);
			n += wave;
		end
		chk("buzz_dur", 16'h0, 16'(n));
		qual = '0;
		bz_en = 1'b0;
		st_en = 1'b1;
		st_flt = 7'h10;
		do_reset();
		chk("fault", 7'h10, flt);
		chk("scan_en", 7'h6f, scan_en);
		chk("beep_start", 1'b1, wave);
		n = 0;
		// idle level before the beep, so its first rise counts too
		pv = 1'b0;
		repeat (2100 * MS) begin
			step(1);
			n += (wave != pv);
			pv = wave;
		end
		chk("beep_toggles", 16'h0008, 16'(n));
		chk("beep_end", 1'b0, wave);
		summarize();
	end
endmodule
